// ==== rtl/pmc_pkg.sv ====
// Package with the offsets, field layouts, reset values and request carriers of the
// power management control/status block.
// Assumes a configuration port with dword addressing and per-byte write enables.
package pmc_pkg;

	localparam logic [7:0]  PMC_CSR_OFFSET      = 8'h54;
	localparam logic [7:0]  PMC_BSE_OFFSET      = 8'h56;
	localparam logic [5:0]  PMC_PM_DWORD        = PMC_CSR_OFFSET[7:2];
	localparam int          PMC_CSR_LANE        = 0;
	localparam int          PMC_BSE_LANE        = 2;

	localparam logic [15:0] PMC_CSR_RESET       = 16'h0008;
	localparam logic [7:0]  PMC_BSE_RESET       = 8'h40;

	localparam int          PMC_WAKE_FLAG_BIT   = 15;
	localparam int          PMC_WAKE_EN_BIT     = 8;
	localparam int          PMC_NO_SOFT_RST_BIT = 3;
	localparam int          PMC_CLK_STOP_BIT    = 7;
	localparam int          PMC_BUS_STATE_BIT   = 6;
	localparam logic        PMC_WAKE_EN_RESET   = 1'h0;
	localparam logic        PMC_BUS_STATE_B2    = 1'h1;

	typedef enum logic [1:0] {
		PMC_D0    = 2'h0,
		PMC_D1    = 2'h1,
		PMC_D2    = 2'h2,
		PMC_D3HOT = 2'h3
	} pmc_dstate_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [5:0]  dword;
		logic [3:0]  be;
		logic [31:0] wdata;
	} pmc_cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic        hit;
		logic [31:0] rdata;
	} pmc_cfg_rsp_t;

	// Builds the control/status value; all data and reserved fields and wake status read zero; no-soft-reset bit 3 follows compat.
	function automatic logic [15:0] pmc_csr_value(input pmc_dstate_t lvl,
		input logic wake_en, input logic compat);
		logic [15:0] v;
		v                      = 16'h0000;
		v[1:0]                 = lvl;
		v[PMC_NO_SOFT_RST_BIT] = compat;
		v[PMC_WAKE_EN_BIT]     = wake_en;
		return v;
	endfunction

	// Builds the bridge support extension value.
	function automatic logic [7:0] pmc_bse_value(input logic clk_stop_en);
		logic [7:0] v;
		v                    = 8'h00;
		v[PMC_CLK_STOP_BIT]  = clk_stop_en;
		v[PMC_BUS_STATE_BIT] = PMC_BUS_STATE_B2;
		return v;
	endfunction

endpackage

// ==== rtl/pmc_power_csr.sv ====
// Power management control/status and bridge support extension registers.
// Assumes configuration requests and the two general control bits come from core_clk logic.
//
// Functional notes
// - D3hot to D0 keeps context, no reset.
// - Wake event status bit 15 reads zero.
// - Data scale bits 14:13 read zero.
// - Data select bits 12:9 read zero.
// - Bit 8 is plain read/write scratch.
// - Compat select low: bit 3 reads zero.
// - Compat select high: bit 3 reads one.
// - Power field readable, write sets new state.
// - Power encoding D0..D3hot, reset D0.
// - Reserved bits 7:4 and 2 read zero.
// - Extension bit 7 mirrors clock stop enable.
// - One means secondary clocks stop in D3.
// - Extension bit 6 always reads one.
// - Extension bits 5:0 read zero.
`timescale 1ns/10ps
module pmc_power_csr (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire pmc_pkg::pmc_cfg_req_t cfg_req,
	output pmc_pkg::pmc_cfg_rsp_t      cfg_rsp,
	input  wire logic                  compat_revision_select,
	input  wire logic                  secondary_clock_stop_enable,
	output pmc_pkg::pmc_dstate_t       device_power_level,
	output logic                       wake_enable_scratch
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode and write enables.

	logic               pm_hit;
	logic               wr_level;
	logic               wr_wake;
	logic [1:0]         level_q;
	logic [15:0]        csr_value;
	logic [7:0]         bse_value;
	logic [31:0]        dword_value;
	pmc_pkg::pmc_cfg_rsp_t next_rsp;

	assign pm_hit   = (cfg_req.dword == pmc_pkg::PMC_PM_DWORD);
	// Only the power field and the scratch bit have storage behind them.
	assign wr_level = cfg_req.wr && pm_hit && cfg_req.be[pmc_pkg::PMC_CSR_LANE];
	assign wr_wake  = cfg_req.wr && pm_hit && cfg_req.be[pmc_pkg::PMC_CSR_LANE + 1];

	////////////////////////////////////////////////////////////////////////////////
	// Stored fields. Power state changes never reset any other state.

	pmc_store_field #(
		.W       (2),
		.RST_VAL (pmc_pkg::PMC_CSR_RESET[1:0])
	) u_level (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_level),
		.wdata    (cfg_req.wdata[1:0]),
		.q        (level_q)
	);

	assign device_power_level = pmc_pkg::pmc_dstate_t'(level_q);

	pmc_store_field #(
		.W       (1),
		.RST_VAL (pmc_pkg::PMC_WAKE_EN_RESET)
	) u_wake (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_wake),
		.wdata    (cfg_req.wdata[pmc_pkg::PMC_WAKE_EN_BIT]),
		.q        (wake_enable_scratch)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data and answer, one cycle after each request.

	// Constant-zero fields and the no-soft-reset status come from the value function.
	assign csr_value   = pmc_pkg::pmc_csr_value(device_power_level, wake_enable_scratch,
		compat_revision_select);
	assign bse_value   = pmc_pkg::pmc_bse_value(secondary_clock_stop_enable);
	assign dword_value = {8'h00, bse_value, csr_value};

	always_comb begin
		next_rsp       = '0;
		next_rsp.ack   = cfg_req.rd || cfg_req.wr;
		next_rsp.hit   = (cfg_req.rd || cfg_req.wr) && pm_hit;
		if (cfg_req.rd && pm_hit) begin
			next_rsp.rdata = dword_value;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_rsp <= '0;
		end else begin
			cfg_rsp <= next_rsp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic rd_hit;
	assign rd_hit = cfg_req.rd && pm_hit;

	property p_no_reset_on_wake;
		($past(device_power_level) == pmc_pkg::PMC_D3HOT) &&
		(device_power_level == pmc_pkg::PMC_D0) && !$past(wr_wake)
		|-> $stable(wake_enable_scratch);
	endproperty
	a_no_reset_on_wake: assert property (p_no_reset_on_wake) else $error("Context lost.");

	property p_const_zero_csr;
		cfg_rsp.rdata[15:9] == 7'h00;
	endproperty
	a_const_zero_csr: assert property (p_const_zero_csr) else $error("Bits 15:9 set.");

	property p_wake_store;
		wr_wake |=> wake_enable_scratch == $past(cfg_req.wdata[pmc_pkg::PMC_WAKE_EN_BIT]);
	endproperty
	a_wake_store: assert property (p_wake_store) else $error("Scratch bit lost.");

	property p_nsr_low;
		rd_hit && !compat_revision_select |=> !cfg_rsp.rdata[3];
	endproperty
	a_nsr_low: assert property (p_nsr_low) else $error("Bit 3 should be zero.");

	property p_nsr_high;
		rd_hit && compat_revision_select |=> cfg_rsp.rdata[3];
	endproperty
	a_nsr_high: assert property (p_nsr_high) else $error("Bit 3 should be one.");

	property p_level_write;
		wr_level ##1 rd_hit |=> cfg_rsp.rdata[1:0] == $past(cfg_req.wdata[1:0], 2);
	endproperty
	a_level_write: assert property (p_level_write) else $error("Power state readback.");

	property p_rsvd_csr;
		(cfg_rsp.rdata[7:4] == 4'h0) && !cfg_rsp.rdata[2];
	endproperty
	a_rsvd_csr: assert property (p_rsvd_csr) else $error("Reserved bits set.");

	property p_bse_mirror;
		rd_hit |=> cfg_rsp.rdata[23] == $past(secondary_clock_stop_enable);
	endproperty
	a_bse_mirror: assert property (p_bse_mirror) else $error("Clock stop mirror.");

	property p_bse_fixed;
		rd_hit |=> cfg_rsp.rdata[22] && (cfg_rsp.rdata[21:16] == 6'h00) && cfg_rsp.ack;
	endproperty
	a_bse_fixed: assert property (p_bse_fixed) else $error("Extension fixed bits.");

	property p_ro_ignored;
		!wr_level && !wr_wake |=> $stable(device_power_level) && $stable(wake_enable_scratch);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("State changed without write.");

	property p_reset_values;
		disable iff (1'b0)
		rst |-> (device_power_level == pmc_pkg::PMC_D0) &&
			(wake_enable_scratch == pmc_pkg::PMC_WAKE_EN_RESET) && (cfg_rsp == '0);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("Bad reset.");

	property p_level_store;
		wr_level |=> device_power_level == $past(cfg_req.wdata[1:0]);
	endproperty
	a_level_store: assert property (p_level_store) else $error("Level not stored.");

	property p_level_keeps_scratch;
		wr_level && !wr_wake |=> $stable(wake_enable_scratch);
	endproperty
	a_level_keeps_scratch: assert property (p_level_keeps_scratch) else $error("Scratch lost.");

	property p_foreign_write;
		cfg_req.wr && !pm_hit |=> $stable(device_power_level) && $stable(wake_enable_scratch);
	endproperty
	a_foreign_write: assert property (p_foreign_write) else $error("Other dword wrote.");

	property p_upper_lane_write;
		cfg_req.wr && pm_hit && !cfg_req.be[pmc_pkg::PMC_CSR_LANE] |=> $stable(device_power_level);
	endproperty
	a_upper_lane_write: assert property (p_upper_lane_write) else $error("Lane leak.");

	property p_read_state;
		rd_hit |=> (cfg_rsp.rdata[1:0] == $past(level_q)) &&
			(cfg_rsp.rdata[pmc_pkg::PMC_WAKE_EN_BIT] == $past(wake_enable_scratch));
	endproperty
	a_read_state: assert property (p_read_state) else $error("Read state wrong.");

	property p_answer;
		(cfg_req.rd || cfg_req.wr) |=> cfg_rsp.ack && (cfg_rsp.hit == $past(pm_hit));
	endproperty
	a_answer: assert property (p_answer) else $error("No answer.");

	property p_quiet;
		!cfg_req.rd && !cfg_req.wr |=>
			!cfg_rsp.ack && !cfg_rsp.hit && (cfg_rsp.rdata == 32'h00000000);
	endproperty
	a_quiet: assert property (p_quiet) else $error("Answer without request.");

	property p_no_read_data;
		!rd_hit |=> cfg_rsp.rdata == 32'h00000000;
	endproperty
	a_no_read_data: assert property (p_no_read_data) else $error("Stray read data.");

	property p_miss;
		cfg_req.rd && !pm_hit |=> cfg_rsp.ack && !cfg_rsp.hit;
	endproperty
	a_miss: assert property (p_miss) else $error("Miss shown as hit.");

	property p_top_byte;
		rd_hit |=> cfg_rsp.rdata[31:24] == 8'h00;
	endproperty
	a_top_byte: assert property (p_top_byte) else $error("Data byte set.");

	c_enter_d3:   cover property (wr_level && cfg_req.wdata[1:0] == 2'h3);
	c_d3_to_d0:   cover property ((device_power_level == pmc_pkg::PMC_D3HOT) ##1
		(device_power_level == pmc_pkg::PMC_D0));
	c_read_compat: cover property (rd_hit && compat_revision_select);
	c_miss:       cover property (cfg_req.rd && !pm_hit);
	c_scratch:    cover property (wr_wake && cfg_req.wdata[pmc_pkg::PMC_WAKE_EN_BIT]);

endmodule

// ==== rtl/pmc_store_field.sv ====
// Write-only-when-enabled storage field of a configuration register.
// Assumes the write enable and data come from logic on the same clock.
`timescale 1ns/10ps
module pmc_store_field #(
	parameter int             W       = 2,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] q
);

	logic [W-1:0] next_q;

	always_comb begin
		next_q = q;
		if (wr_en) begin
			next_q = wdata;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= RST_VAL;
		end else begin
			q <= next_q;
		end
	end

endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the power management control/status block.
// Assumes the block answers every access at the edge that takes it.
`timescale 1ns/10ps
module tb;
	localparam logic [5:0] PM = pmc_pkg::PMC_PM_DWORD;
	logic                  core_clk;
	logic                  rst;
	pmc_pkg::pmc_cfg_req_t cfg_req;
	pmc_pkg::pmc_cfg_rsp_t cfg_rsp;
	logic                  compat_revision_select;
	logic                  secondary_clock_stop_enable;
	pmc_pkg::pmc_dstate_t  device_power_level;
	logic                  wake_enable_scratch;
	int                    errors;
	int                    n_tests;
	logic [1:0]            m_lvl;
	logic                  m_we;
	logic [32:0]           notes[$];
	logic [31:0]           r;

	pmc_power_csr pmc_power_csr_i (
		.core_clk                    (core_clk),
		.rst                         (rst),
		.cfg_req                     (cfg_req),
		.cfg_rsp                     (cfg_rsp),
		.compat_revision_select      (compat_revision_select),
		.secondary_clock_stop_enable (secondary_clock_stop_enable),
		.device_power_level          (device_power_level),
		.wake_enable_scratch         (wake_enable_scratch)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic finish_test();
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Presents one request, notes its answer, and updates the model at the taking edge.
	task automatic access(input logic rd, input logic wr, input logic [5:0] dw,
		input logic [3:0] be, input logic [31:0] wd);
		logic [1:0] ck;
		logic       hit;
		ck = 2'($urandom);
		hit = (dw == PM);
		compat_revision_select <= ck[0];
		secondary_clock_stop_enable <= ck[1];
		cfg_req <= '{rd: rd, wr: wr, dword: dw, be: be, wdata: wd};
		notes.push_back({hit, (rd && hit) ? {8'h00, ck[1], 1'b1, 6'h00, 7'h00, m_we, 4'h0,
			ck[0], 1'b0, m_lvl} : 32'h00000000});
		@(posedge core_clk);
		if (wr && hit && be[0])
			m_lvl = wd[1:0];
		if (wr && hit && be[1])
			m_we = wd[8];
	endtask

	task automatic do_reset();
		cfg_req <= '0;
		@(posedge core_clk);
		rst <= 1'b1;
		m_lvl = 2'h0;
		m_we = 1'b0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watches the outputs and compares each answer with the oldest note.
	always @(negedge core_clk) begin
		check("power_level", 33'(m_lvl), 33'(device_power_level));
		check("wake_scratch", 33'(m_we), 33'(wake_enable_scratch));
		if (cfg_rsp.ack === 1'b1) begin
			if (notes.size() == 0)
				check("stray_ack", 33'h000000000, 33'h100000000);
			else
				check("response", notes.pop_front(), {cfg_rsp.hit, cfg_rsp.rdata});
		end
	end

	initial begin
		#(40 * 3000);
		errors++;
		finish_test();
	end

	initial begin
		errors = 0;
		n_tests = 0;
		m_lvl = 2'h0;
		m_we = 1'b0;
		rst = 1'b1;
		cfg_req = '0;
		compat_revision_select = 1'b0;
		secondary_clock_stop_enable = 1'b0;
		r = $urandom(32'hE92725CE);
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			access(1'b0, 1'b1, PM, 4'hF, 32'hFFFFFFFC | 32'(i));
			access(1'b1, 1'b0, PM, 4'h0, 32'h00000000);
		end
		access(1'b0, 1'b1, PM, 4'h1, 32'h00000000);
		access(1'b1, 1'b1, PM, 4'h3, 32'h00000002);
		access(1'b0, 1'b1, 6'h14, 4'hF, 32'hFFFFFFFF);
		access(1'b1, 1'b0, PM, 4'h0, 32'h00000000);
		for (int i = 0; i < 300; i++) begin
			r = $urandom;
			access(r[0], r[1] | ~r[0], r[2] ? PM : r[8:3], r[12:9], $urandom);
		end
		do_reset();
		access(1'b1, 1'b0, PM, 4'h0, 32'h00000000);
		cfg_req <= '0;
		repeat (3) @(posedge core_clk);
		check("notes_left", 33'h000000000, 33'(notes.size()));
		finish_test();
	end
endmodule
